/* File: pkg/pmwc_pkg.sv */
// Constants, register map and carrier types for the power mode and wake control block.
// Assumes one clock domain on REF_CLK and a one-cycle-latency register port.
//
// What this block does
// - Writing one to idle request bit enters idle after that write.
// - Idle stops only the processor clock; peripherals run, pins freeze.
// - Enabled interrupt in idle clears idle bit, wakes, resumes after entry.
// - Reset from pin, power-on or watchdog; each also ends idle.
// - Reset pin counts only after 24 clocks high; source must hold it.
// - Reset loads program counter 0000h and resets registers, no delay.
// - Writing one to power-down request bit enters power-down after that write.
// - Power-down stops every clock; pins keep driving port register values.
// - Reset pin high in power-down restarts oscillator, starts at 0000h.
// - Watchdog cannot wake power-down because its clock is stopped.
// - Level-mode enabled external input with global enable wakes power-down.
// - After power-down wake the external service routine runs, then resumes.
// - External inputs sampled once per machine cycle; edges need one cycle each.
// - Edge request flag set by transition, cleared when processor vectors.
// - Level request flag tracks pin; asserted level re-requests after routine.
// - Enabled external interrupt wakes processor from idle; only level-mode ones wake power-down.
// - Auxiliary port has four bits; two are extra external interrupt inputs.
// - Power control bit 1 requests power-down, bit 0 requests idle.

package pmwc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int MC_CLKS = 12;
  localparam int RST_MIN_NS = 960;
  localparam int RST_MIN_CLKS = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int N_EXT = 4;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_PWR_CTRL = 8'h87;
  localparam logic [7:0] ADDR_TMR_IRQ = 8'h88;
  localparam logic [7:0] ADDR_IRQ_EN = 8'ha8;
  localparam logic [7:0] ADDR_XCON = 8'hc0;
  localparam logic [7:0] ADDR_AUX = 8'hd8;
  localparam logic [7:0] ADDR_STAT = 8'he8;
  localparam logic [7:0] ADDR_MASK = 8'he9;

  localparam int PWR_IDLE_REQ = 0;
  localparam int PWR_DOWN_REQ = 1;
  localparam int PC_W = 4;
  localparam int TC_TRIG0 = 0;
  localparam int TC_FLAG0 = 1;
  localparam int TC_TRIG1 = 2;
  localparam int TC_FLAG1 = 3;
  localparam int XC_TRIG2 = 0;
  localparam int XC_FLAG2 = 1;
  localparam int XC_TRIG3 = 2;
  localparam int XC_FLAG3 = 3;
  localparam int IRQ_EN_GLOBAL = 7;

  localparam int ST_IDLE_WAKE = 0;
  localparam int ST_PDOWN_WAKE = 1;
  localparam int ST_PIN_RST = 2;
  localparam int ST_WDT_RST = 3;
  localparam int ST_EXT_EDGE = 4;
  localparam int ST_W = 5;

  localparam logic [PC_W-1:0] POWER_CONTROL_REG_RST = 4'h0;
  localparam logic [3:0] NIB_RST = 4'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [ST_W-1:0] STAT_RST = 5'h00;
  localparam logic [15:0] RESET_PC_VAL = 16'h0000;

  typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_PDOWN} pmwc_mode_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pmwc_bus_s;

endpackage

/* File: design/pmwc_sync.sv */
// Two-flop synchroniser for asynchronous pin levels.
// Assumes inputs arrive from outside the REF_CLK domain.
`timescale 1ns/1ns

module pmwc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule

/* File: design/pmwc_rst_qual.sv */
// Reset pin qualifier: a level is accepted only after HOLD clocks high.
// Assumes the level input is already synchronised to clk.
`timescale 1ns/1ns

module pmwc_rst_qual #(
  parameter int HOLD = pmwc_pkg::RST_MIN_CLKS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic lvl,
  output logic valid
);

  localparam int CW = $clog2(HOLD + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(HOLD);
  localparam logic [CW-1:0] CNT_ARM = CW'(HOLD - 1);

  logic [CW-1:0] cnt_ff;
  logic valid_ff;

  // Short glitches restart the count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= '0;
    end else if (!lvl) begin
      cnt_ff <= '0;
    end else if (cnt_ff != CNT_MAX) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= lvl && (cnt_ff >= CNT_ARM);
    end
  end

  assign valid = valid_ff;

endmodule

/* File: design/pmwc_top.sv */
// Power mode and wake control: idle and power-down modes, reset sources,
// external interrupt sampling and request flags, status and mask registers.
// Assumes REF_CLK keeps reaching this block in power-down (always-on wake
// logic); the clocks it gates are those of the core and the peripherals.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ns

module pmwc_top (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic RST_PIN,
  input wire logic WDT_TIMEOUT,
  input wire logic PERIPH_IRQ,
  input wire logic [1:0] EXT_IRQ_N,
  input wire logic [3:0] AUX_PIN,
  input wire logic [3:0] IRQ_ACK,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic CPU_CLK_EN,
  output logic PERIPH_CLK_EN,
  output logic OSC_RUN,
  output logic PORT_FREEZE,
  output logic CORE_RST,
  output logic [15:0] RESET_PC,
  output logic [3:0] EXT_IRQ_REQ,
  output logic IRQ_OUT
);

  localparam int NE = pmwc_pkg::N_EXT;
  localparam logic [3:0] MC_LAST = 4'(pmwc_pkg::MC_CLKS - 1);

  // ****************************************
  // Synchronisers and reset sources
  // ****************************************
  logic [6:0] pins_s;
  logic pin_rst_s;
  logic [NE-1:0] ext_lvl;
  logic rst_valid;
  logic rst_valid_d_ff;
  logic wdt_rst;
  logic sw_rst;
  pmwc_pkg::pmwc_bus_s bus;
  pmwc_pkg::pmwc_mode_e state_ff;
  pmwc_pkg::pmwc_mode_e nxt_state;

  assign bus = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};

  pmwc_sync #(.W(7)) u_sync (
    .clk(REF_CLK),
    .rstn(RSTN),
    .d({RST_PIN, AUX_PIN[3], AUX_PIN[2], AUX_PIN[1], AUX_PIN[0], EXT_IRQ_N}),
    .q(pins_s)
  );

  assign pin_rst_s = pins_s[6];
  // aux bits 2 and 3 double as external inputs
  assign ext_lvl = {pins_s[5], pins_s[4], pins_s[1], pins_s[0]};

  // pin reset qualified by hold time
  pmwc_rst_qual #(.HOLD(pmwc_pkg::RST_MIN_CLKS)) u_rst_qual (
    .clk(REF_CLK),
    .rstn(RSTN),
    .lvl(pin_rst_s),
    .valid(rst_valid)
  );

  assign wdt_rst = WDT_TIMEOUT && (state_ff != pmwc_pkg::PM_PDOWN);
  // pin or watchdog reset, also ending idle
  assign sw_rst = rst_valid || wdt_rst;

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_valid_d_ff <= 1'b0;
    end else begin
      rst_valid_d_ff <= rst_valid;
    end
  end

  // ****************************************
  // Register decode
  // ****************************************
  logic pwr_wr;
  logic tmr_wr;
  logic irq_en_wr;
  logic xcon_wr;
  logic mask_wr;
  logic stat_rd;

  always_comb begin
    pwr_wr = 1'b0;
    tmr_wr = 1'b0;
    irq_en_wr = 1'b0;
    xcon_wr = 1'b0;
    mask_wr = 1'b0;
    if (bus.addr == pmwc_pkg::ADDR_PWR_CTRL) begin
      pwr_wr = bus.wr;
    end else if (bus.addr == pmwc_pkg::ADDR_TMR_IRQ) begin
      tmr_wr = bus.wr;
    end else if (bus.addr == pmwc_pkg::ADDR_IRQ_EN) begin
      irq_en_wr = bus.wr;
    end else if (bus.addr == pmwc_pkg::ADDR_XCON) begin
      xcon_wr = bus.wr;
    end else if (bus.addr == pmwc_pkg::ADDR_MASK) begin
      mask_wr = bus.wr;
    end
  end

  assign stat_rd = bus.rd && (bus.addr == pmwc_pkg::ADDR_STAT);

  // ****************************************
  // Control registers
  // ****************************************
  logic [pmwc_pkg::PC_W-1:0] pwr_ctrl_ff;
  logic [3:0] tmr_bits_ff;
  logic [7:0] irq_en_ff;
  logic [NE-1:0] it_ff;
  logic [NE-1:0] flag_ff;
  logic [NE-1:0] flag_wr;
  logic [NE-1:0] flag_wval;
  logic [NE-1:0] it_wr;
  logic [NE-1:0] it_wval;
  logic gie;
  logic idle_wake;
  logic pdown_wake;

  assign gie = irq_en_ff[pmwc_pkg::IRQ_EN_GLOBAL];
  assign flag_wr = {xcon_wr, xcon_wr, tmr_wr, tmr_wr};
  assign it_wr = flag_wr;
  assign flag_wval = {bus.wdata[pmwc_pkg::XC_FLAG3], bus.wdata[pmwc_pkg::XC_FLAG2],
                      bus.wdata[pmwc_pkg::TC_FLAG1], bus.wdata[pmwc_pkg::TC_FLAG0]};
  assign it_wval = {bus.wdata[pmwc_pkg::XC_TRIG3], bus.wdata[pmwc_pkg::XC_TRIG2],
                    bus.wdata[pmwc_pkg::TC_TRIG1], bus.wdata[pmwc_pkg::TC_TRIG0]};

  assign idle_wake = PERIPH_IRQ || (gie && |(flag_ff & irq_en_ff[NE-1:0]));
  // only enabled level-mode inputs, low level, global enable
  assign pdown_wake = gie && |(irq_en_ff[NE-1:0] & ~it_ff & ~ext_lvl);

  // power control bits; cleared by any reset
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pwr_ctrl_ff <= pmwc_pkg::POWER_CONTROL_REG_RST;
    end else if (sw_rst) begin
      pwr_ctrl_ff <= pmwc_pkg::POWER_CONTROL_REG_RST;
    end else if (pwr_wr) begin
      pwr_ctrl_ff <= bus.wdata[pmwc_pkg::PC_W-1:0];
    end else if ((state_ff != pmwc_pkg::PM_RUN) && (nxt_state == pmwc_pkg::PM_RUN)) begin
      // hardware clears the request on wake
      pwr_ctrl_ff[pmwc_pkg::PWR_IDLE_REQ] <= 1'b0;
      pwr_ctrl_ff[pmwc_pkg::PWR_DOWN_REQ] <= 1'b0;
    end
  end

  // special function registers back to reset values
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tmr_bits_ff <= pmwc_pkg::NIB_RST;
      irq_en_ff <= pmwc_pkg::BYTE_ZERO;
    end else if (sw_rst) begin
      tmr_bits_ff <= pmwc_pkg::NIB_RST;
      irq_en_ff <= pmwc_pkg::BYTE_ZERO;
    end else begin
      if (tmr_wr) begin
        tmr_bits_ff <= bus.wdata[7:4];
      end
      if (irq_en_wr) begin
        irq_en_ff <= bus.wdata;
      end
    end
  end

  // ****************************************
  // Mode state machine
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    if (sw_rst) begin
      nxt_state = pmwc_pkg::PM_RUN;
    end else begin
      case (state_ff)
        pmwc_pkg::PM_RUN: begin
          if (pwr_wr && bus.wdata[pmwc_pkg::PWR_DOWN_REQ]) begin
            nxt_state = pmwc_pkg::PM_PDOWN;
          end else if (pwr_wr && bus.wdata[pmwc_pkg::PWR_IDLE_REQ]) begin
            nxt_state = pmwc_pkg::PM_IDLE;
          end
        end
        pmwc_pkg::PM_IDLE: begin
          if (idle_wake) begin
            nxt_state = pmwc_pkg::PM_RUN;
          end
        end
        pmwc_pkg::PM_PDOWN: begin
          if (pdown_wake) begin
            nxt_state = pmwc_pkg::PM_RUN;
          end
        end
        default: begin
          nxt_state = pmwc_pkg::PM_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_ff <= pmwc_pkg::PM_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // idle gates core clock only; power-down gates all
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      CPU_CLK_EN <= 1'b1;
      PERIPH_CLK_EN <= 1'b1;
      PORT_FREEZE <= 1'b0;
      OSC_RUN <= 1'b1;
    end else begin
      CPU_CLK_EN <= (nxt_state == pmwc_pkg::PM_RUN);
      PERIPH_CLK_EN <= (nxt_state != pmwc_pkg::PM_PDOWN);
      PORT_FREEZE <= (nxt_state != pmwc_pkg::PM_RUN);
      // reset pin restarts the oscillator at once
      OSC_RUN <= (nxt_state != pmwc_pkg::PM_PDOWN) || pin_rst_s;
    end
  end

  // core reset and start address, no added delay
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      CORE_RST <= 1'b1;
      RESET_PC <= pmwc_pkg::RESET_PC_VAL;
    end else begin
      CORE_RST <= sw_rst;
      RESET_PC <= pmwc_pkg::RESET_PC_VAL;
    end
  end

  // ****************************************
  // External interrupt sampling
  // ****************************************
  logic [3:0] mc_cnt_ff;
  logic mc_tick;
  logic [NE-1:0] samp_ff;
  logic [NE-1:0] edge_set;

  // one sample per machine cycle; halted with the clocks
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      mc_cnt_ff <= 4'h0;
    end else if (state_ff == pmwc_pkg::PM_PDOWN) begin
      mc_cnt_ff <= 4'h0;
    end else if (mc_cnt_ff == MC_LAST) begin
      mc_cnt_ff <= 4'h0;
    end else begin
      mc_cnt_ff <= mc_cnt_ff + 4'h1;
    end
  end

  assign mc_tick = (mc_cnt_ff == MC_LAST) && (state_ff != pmwc_pkg::PM_PDOWN);

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      samp_ff <= {NE{1'b1}};
    end else if (mc_tick) begin
      samp_ff <= ext_lvl;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NE; gi++) begin : g_ext
      // high sample then low sample is one edge
      assign edge_set[gi] = mc_tick && it_ff[gi] && samp_ff[gi] && !ext_lvl[gi];

      always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
          it_ff[gi] <= 1'b0;
        end else if (sw_rst) begin
          it_ff[gi] <= 1'b0;
        end else if (it_wr[gi]) begin
          it_ff[gi] <= it_wval[gi];
        end
      end

      always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
          flag_ff[gi] <= 1'b0;
        end else if (sw_rst) begin
          flag_ff[gi] <= 1'b0;
        end else if (!it_ff[gi]) begin
          // level flag tracks the pin, also on power-down wake
          if (mc_tick || (state_ff == pmwc_pkg::PM_PDOWN && pdown_wake)) begin
            flag_ff[gi] <= !ext_lvl[gi];
          end
        // transition sets, vectoring clears; set wins
        end else if (edge_set[gi]) begin
          flag_ff[gi] <= 1'b1;
        end else if (IRQ_ACK[gi]) begin
          flag_ff[gi] <= 1'b0;
        end else if (flag_wr[gi]) begin
          flag_ff[gi] <= flag_wval[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      EXT_IRQ_REQ <= '0;
    end else begin
      EXT_IRQ_REQ <= flag_ff & irq_en_ff[NE-1:0] & {NE{gie}};
    end
  end

  // ****************************************
  // Status, mask and interrupt output
  // ****************************************
  logic [pmwc_pkg::ST_W-1:0] stat_ff;
  logic [pmwc_pkg::ST_W-1:0] mask_ff;
  logic [pmwc_pkg::ST_W-1:0] stat_set;

  always_comb begin
    stat_set = '0;
    stat_set[pmwc_pkg::ST_IDLE_WAKE] = (state_ff == pmwc_pkg::PM_IDLE) && idle_wake && !sw_rst;
    stat_set[pmwc_pkg::ST_PDOWN_WAKE] = (state_ff == pmwc_pkg::PM_PDOWN) && pdown_wake && !sw_rst;
    stat_set[pmwc_pkg::ST_PIN_RST] = rst_valid && !rst_valid_d_ff;
    stat_set[pmwc_pkg::ST_WDT_RST] = wdt_rst;
    stat_set[pmwc_pkg::ST_EXT_EDGE] = |edge_set;
  end

  // Read clears, a new event in the same cycle survives
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      stat_ff <= pmwc_pkg::STAT_RST;
    end else if (stat_rd) begin
      stat_ff <= stat_set;
    end else begin
      stat_ff <= stat_ff | stat_set;
    end
  end

  // Survives pin and watchdog reset so software can see the cause
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      mask_ff <= pmwc_pkg::STAT_RST;
    end else if (mask_wr) begin
      mask_ff <= bus.wdata[pmwc_pkg::ST_W-1:0];
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= |(stat_ff & mask_ff);
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      REG_RDATA <= pmwc_pkg::BYTE_ZERO;
    end else if (!bus.rd) begin
      REG_RDATA <= pmwc_pkg::BYTE_ZERO;
    end else if (bus.addr == pmwc_pkg::ADDR_PWR_CTRL) begin
      REG_RDATA <= {4'h0, pwr_ctrl_ff};
    end else if (bus.addr == pmwc_pkg::ADDR_TMR_IRQ) begin
      REG_RDATA <= {tmr_bits_ff, flag_ff[1], it_ff[1], flag_ff[0], it_ff[0]};
    end else if (bus.addr == pmwc_pkg::ADDR_IRQ_EN) begin
      REG_RDATA <= irq_en_ff;
    end else if (bus.addr == pmwc_pkg::ADDR_XCON) begin
      REG_RDATA <= {4'h0, flag_ff[3], it_ff[3], flag_ff[2], it_ff[2]};
    end else if (bus.addr == pmwc_pkg::ADDR_AUX) begin
      REG_RDATA <= {4'h0, pins_s[5:2]};
    end else if (bus.addr == pmwc_pkg::ADDR_STAT) begin
      REG_RDATA <= {3'h0, stat_ff};
    end else if (bus.addr == pmwc_pkg::ADDR_MASK) begin
      REG_RDATA <= {3'h0, mask_ff};
    end else begin
      REG_RDATA <= pmwc_pkg::BYTE_ZERO;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  logic [5:0] hi_cnt_ff;
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      hi_cnt_ff <= 6'h00;
    end else if (!pin_rst_s) begin
      hi_cnt_ff <= 6'h00;
    end else if (hi_cnt_ff != 6'h3f) begin
      hi_cnt_ff <= hi_cnt_ff + 6'h01;
    end
  end

  sequence s_idle_req;
    state_ff == pmwc_pkg::PM_RUN && pwr_wr && bus.wdata[pmwc_pkg::PWR_IDLE_REQ]
      && !bus.wdata[pmwc_pkg::PWR_DOWN_REQ] && !sw_rst;
  endsequence

  // Input 1 is one of the two (1 and 3) the bench drives in edge mode
  sequence s_edge_seen;
    mc_tick && it_ff[1] && samp_ff[1] && !ext_lvl[1] && !sw_rst;
  endsequence

  a_idle_entry: assert property (s_idle_req |=> state_ff == pmwc_pkg::PM_IDLE
    && !CPU_CLK_EN && PERIPH_CLK_EN && PORT_FREEZE)
    else $error("idle not entered after request");
  a_idle_wake: assert property (state_ff == pmwc_pkg::PM_IDLE && idle_wake && !sw_rst
    |=> state_ff == pmwc_pkg::PM_RUN && !pwr_ctrl_ff[pmwc_pkg::PWR_IDLE_REQ] ##1 CPU_CLK_EN)
    else $error("idle wake failed");
  a_rst_hold: assert property ($rose(rst_valid) |-> hi_cnt_ff == 6'd24)
    else $error("reset accepted at wrong hold time");
  a_rst_clears: assert property (sw_rst |=> CORE_RST && pwr_ctrl_ff == '0
    && state_ff == pmwc_pkg::PM_RUN)
    else $error("reset did not clear mode");
  a_pdown_stop: assert property (state_ff == pmwc_pkg::PM_PDOWN && !$past(pin_rst_s)
    && $past(state_ff) == pmwc_pkg::PM_PDOWN |-> !OSC_RUN && !PERIPH_CLK_EN)
    else $error("clock running in power-down");
  a_wdt_blocked: assert property (state_ff == pmwc_pkg::PM_PDOWN && WDT_TIMEOUT
    && !rst_valid && !pdown_wake |=> state_ff == pmwc_pkg::PM_PDOWN && !CORE_RST)
    else $error("watchdog woke power-down");
  a_pdown_wake: assert property (state_ff == pmwc_pkg::PM_PDOWN && pdown_wake && !sw_rst
    |=> state_ff == pmwc_pkg::PM_RUN && !pwr_ctrl_ff[pmwc_pkg::PWR_DOWN_REQ] ##1 OSC_RUN)
    else $error("level wake failed");
  a_edge_set: assert property (s_edge_seen |=> flag_ff[1] ##1 EXT_IRQ_REQ[1] == (
    $past(gie) && $past(irq_en_ff[1]) && $past(flag_ff[1])))
    else $error("edge flag not set");
  a_level_track: assert property (mc_tick && !it_ff[1] && !sw_rst
    |=> flag_ff[1] == !$past(ext_lvl[1]))
    else $error("level flag does not track pin");
  a_stat_clear: assert property (stat_rd && stat_set == '0
    |=> stat_ff == '0 && REG_RDATA == {3'h0, $past(stat_ff)})
    else $error("status read clear wrong");

endmodule

/* File: dv/pmwc_src_model.sv */
// External interrupt sources and reset circuit in front of the block.
// Assumes the bench pulses edge_req and holds lvl_req and rst_req as levels.
`timescale 1ns/1ns

module pmwc_src_model (
  input wire logic clk,
  input wire logic [3:0] lvl_req,
  input wire logic [3:0] edge_req,
  input wire logic rst_req,
  output logic [1:0] ext_n,
  output logic [3:0] aux,
  output logic rst_pin
);
  int cnt [4] = '{0, 0, 0, 0};
  int rcnt = 0;
  logic [3:0] low;

  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (edge_req[i]) cnt[i] <= 2 * pmwc_pkg::MC_CLKS;
      else if (cnt[i] > 0) cnt[i] <= cnt[i] - 1;
    end
    if (rst_req) rcnt <= 2 * pmwc_pkg::RST_MIN_CLKS;
    else if (rcnt > 0) rcnt <= rcnt - 1;
  end
  assign low = lvl_req | {cnt[3] > 0, cnt[2] > 0, cnt[1] > 0, cnt[0] > 0};
  assign ext_n = ~low[1:0];
  // Low aux bits are plain I/O, held at a fixed pattern
  assign aux = {~low[3:2], 2'b10};
  // pin held well past the minimum
  assign rst_pin = rst_req | (rcnt > 0);
endmodule

/* File: dv/power_mode_wake_control_tb.sv */
// Self-checking bench for the power mode and wake control block.
// Assumes the source model drives the interrupt and reset pins.
`timescale 1ns/1ns

module power_mode_wake_control_tb;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} pmwc_row_s;
  logic clk = 0, rstn = 0, rst_req = 0, wdt = 0, pirq = 0, wr = 0, rd = 0;
  logic [3:0] lvl = 0, edg = 0, ack = 0, req, aux;
  logic [7:0] addr = 0, wdata = 0, rdata;
  logic cpu_en, per_en, osc, frz, crst, irq, rpin;
  logic [15:0] rpc;
  logic [1:0] ext_n;
  int mismatches = 0, cmp_count = 0;
  pmwc_row_s rows [7] = '{'{pmwc_pkg::ADDR_TMR_IRQ, 8'h50, 8'h50},
    '{pmwc_pkg::ADDR_IRQ_EN, 8'h81, 8'h81}, '{pmwc_pkg::ADDR_XCON, 8'h04, 8'h04},
    '{pmwc_pkg::ADDR_MASK, 8'h01, 8'h01}, '{8'h10, 8'hff, 8'h00},
    '{pmwc_pkg::ADDR_AUX, 8'hff, 8'h0e}, '{pmwc_pkg::ADDR_STAT, 8'hff, 8'h00}};

  pmwc_src_model i_src (.clk(clk), .lvl_req(lvl), .edge_req(edg), .rst_req(rst_req),
    .ext_n(ext_n), .aux(aux), .rst_pin(rpin));
  pmwc_top i_dut (.REF_CLK(clk), .RSTN(rstn), .RST_PIN(rpin), .WDT_TIMEOUT(wdt),
    .PERIPH_IRQ(pirq), .EXT_IRQ_N(ext_n), .AUX_PIN(aux), .IRQ_ACK(ack),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .CPU_CLK_EN(cpu_en), .PERIPH_CLK_EN(per_en), .OSC_RUN(osc), .PORT_FREEZE(frz),
    .CORE_RST(crst), .RESET_PC(rpc), .EXT_IRQ_REQ(req), .IRQ_OUT(irq));

  initial begin
    forever #20 clk = ~clk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task results;
    if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return cpu_en;
      1: return osc;
      2: return crst;
      default: return req[s-3];
    endcase
  endfunction

  // Bounded wait, sampled mid-cycle
  task wt(input int s, input logic v, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(negedge clk);
      if (sig(s) === v) return;
    end
    mismatches++;
    $display("wrong value at %0t: wait %0d ran out", $time, s);
    results();
  endtask

  task wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask

  task pulse_edge(input int i);
    @(posedge clk);
    edg[i] <= 1'b1;
    @(posedge clk);
    edg <= 4'h0;
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    @(negedge clk);
    chk(crst, 1'b1);
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(negedge clk);
    chk({crst, cpu_en, per_en, frz}, 4'h6);
    chk(rpc, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      wrr(rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].e);
    end
    wrr(pmwc_pkg::ADDR_PWR_CTRL, 8'h01);
    @(negedge clk);
    chk({cpu_en, per_en, frz}, 3'h3);
    @(posedge clk);
    pirq <= 1'b1;
    wt(0, 1'b1, 4);
    @(posedge clk);
    pirq <= 1'b0;
    rdc(pmwc_pkg::ADDR_PWR_CTRL, 8'h00);
    chk(irq, 1'b1);
    rdc(pmwc_pkg::ADDR_STAT, 8'h01);
    wrr(pmwc_pkg::ADDR_PWR_CTRL, 8'h02);
    @(negedge clk);
    chk({cpu_en, per_en, osc, frz}, 4'h1);
    @(posedge clk);
    wdt <= 1'b1;
    repeat (3) @(posedge clk);
    wdt <= 1'b0;
    @(negedge clk);
    chk({crst, osc}, 2'b00);
    @(posedge clk);
    lvl[0] <= 1'b1;
    wt(1, 1'b1, 8);
    wt(3, 1'b1, 30);
    @(posedge clk);
    lvl[0] <= 1'b0;
    wt(3, 1'b0, 40);
    wrr(pmwc_pkg::ADDR_TMR_IRQ, 8'h54);
    wrr(pmwc_pkg::ADDR_IRQ_EN, 8'h8a);
    for (int i = 1; i < 4; i += 2) begin
      pulse_edge(i);
      wt(3 + i, 1'b1, 60);
      repeat (40) @(negedge clk);
      chk(req[i], 1'b1);
      @(posedge clk);
      ack <= 4'h1 << i;
      @(posedge clk);
      ack <= 4'h0;
      wt(3 + i, 1'b0, 4);
    end
    wrr(pmwc_pkg::ADDR_PWR_CTRL, 8'h02);
    @(posedge clk);
    rst_req <= 1'b1;
    repeat (20) @(negedge clk);
    chk(crst, 1'b0);
    wt(2, 1'b1, 20);
    chk(osc, 1'b1);
    chk(rpc, 16'h0000);
    @(posedge clk);
    rst_req <= 1'b0;
    wt(2, 1'b0, 100);
    rdc(pmwc_pkg::ADDR_PWR_CTRL, 8'h00);
    rdc(pmwc_pkg::ADDR_IRQ_EN, 8'h00);
    @(posedge clk);
    wdt <= 1'b1;
    @(posedge clk);
    wdt <= 1'b0;
    @(negedge clk);
    chk(crst, 1'b1);
    results();
  end
endmodule
